// [hw/baltu_core.sv]
// byte alu datapath: or, increment, logical shifts and move
// Contract
// - or literal: work or literal into work, zero flag updated
// - or file: work or file into chosen destination, zero flag updated
// - increment: file plus one into chosen destination, only zero updated
// - destination bit 0 writes work, 1 writes file register back
// - file address is seven bits, locations 0 to 127
// - left shift: bit 7 to carry, bits 6:0 up, zero in bit 0
// - right shift: bit 0 to carry, bits 7:1 down, zero in bit 7
// - both shifts update carry and zero, result to chosen destination
// - move file copies file unchanged to destination, zero updated, one cycle
// - move with destination 1 rewrites file with itself, zero updated
`timescale 1ns/10ps
`default_nettype none
`include "baltu_defs.svh"
module baltu_core (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire baltu_pkg::baltu_instr_type i_instr,
	output logic [7:0] o_work,
	output baltu_pkg::baltu_flags_type o_flags,
	output logic [7:0] o_result,
	output logic o_done
);
	logic [7:0] work_reg;
	logic [7:0] work_next;
	logic carry_reg;
	logic carry_next;
	logic zero_reg;
	logic zero_next;
	logic [7:0] result_reg;
	logic done_reg;
	logic [7:0] file_mem [0:`BALTU_FILE_DEPTH-1];

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	wire baltu_pkg::baltu_op_type op = i_instr.op;
	wire [6:0] f_addr = i_instr.addr;
	wire [7:0] f_val = file_mem[f_addr];
	wire is_lit = (op == baltu_pkg::or_literal_into_work);
	wire op_known = is_lit || (op == baltu_pkg::or_work_with_file)
		|| (op == baltu_pkg::increment_file) || (op == baltu_pkg::shift_left_logical)
		|| (op == baltu_pkg::shift_right_logical) || (op == baltu_pkg::move_file);
	wire exec = i_instr.valid && op_known;
	wire sh_op = (op == baltu_pkg::shift_left_logical) || (op == baltu_pkg::shift_right_logical);

	wire [7:0] or_lit_res = work_reg | i_instr.literal;
	wire [7:0] or_file_res = work_reg | f_val;
	wire [7:0] inc_res = f_val + `BALTU_INC_STEP;
	wire [7:0] shl_res = {f_val[6:0], 1'b0};
	wire [7:0] shr_res = {1'b0, f_val[7:1]};
	wire shl_c = f_val[7];
	wire shr_c = f_val[0];

	logic [7:0] alu_res;
	always_comb begin
		case (op)
			baltu_pkg::or_literal_into_work: alu_res = or_lit_res;
			baltu_pkg::or_work_with_file: alu_res = or_file_res;
			baltu_pkg::increment_file: alu_res = inc_res;
			baltu_pkg::shift_left_logical: alu_res = shl_res;
			baltu_pkg::shift_right_logical: alu_res = shr_res;
			baltu_pkg::move_file: alu_res = f_val;
			default: alu_res = 8'h00;
		endcase
	end

	// literal op always targets work; file ops follow the destination bit
	wire to_file = exec && !is_lit && (i_instr.dest == `BALTU_DEST_F);
	wire to_work = exec && !to_file;

	always_comb begin
		work_next = to_work ? alu_res : work_reg;
		zero_next = exec ? is_zero(alu_res) : zero_reg;
		carry_next = carry_reg;
		if (exec && op == baltu_pkg::shift_left_logical) begin
			carry_next = shl_c;
		end else if (exec && op == baltu_pkg::shift_right_logical) begin
			carry_next = shr_c;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			work_reg <= `BALTU_W_RESET;
			carry_reg <= `BALTU_FLAG_RESET;
			zero_reg <= `BALTU_FLAG_RESET;
			result_reg <= `BALTU_RESULT_RESET;
			done_reg <= 1'b0;
		end else begin
			work_reg <= work_next;
			carry_reg <= carry_next;
			zero_reg <= zero_next;
			result_reg <= exec ? alu_res : result_reg;
			done_reg <= exec;
		end
	end

	// file storage, cleared at reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < `BALTU_FILE_DEPTH; i++) begin
				file_mem[i] <= `BALTU_FILE_RESET;
			end
		end else if (to_file) begin
			file_mem[f_addr] <= alu_res;
		end
	end

	assign o_work = work_reg;
	assign o_flags = '{carry: carry_reg, zero: zero_reg};
	assign o_result = result_reg;
	assign o_done = done_reg;

	sequence s_shl_issue;
		i_instr.valid && op == baltu_pkg::shift_left_logical;
	endsequence
	sequence s_shr_issue;
		i_instr.valid && op == baltu_pkg::shift_right_logical;
	endsequence

	property p_or_lit;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && is_lit) |=> (o_work == ($past(work_reg) | $past(i_instr.literal)))
			&& o_flags.zero == (o_work == 8'h00) && o_flags.carry == $past(carry_reg);
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

	property p_or_file;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && op == baltu_pkg::or_work_with_file)
			|=> o_result == ($past(work_reg) | $past(f_val)) && o_flags.carry == $past(carry_reg);
	endproperty
	a_or_file: assert property (p_or_file) else $error("or file wrong");

	property p_inc;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && op == baltu_pkg::increment_file)
			|=> o_result == 8'($past(f_val) + 8'h01) && o_flags.carry == $past(carry_reg);
	endproperty
	a_inc: assert property (p_inc) else $error("increment wrong");

	property p_dest_work;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(exec && !is_lit && i_instr.dest == 1'b0) |=> o_work == o_result;
	endproperty
	a_dest_work: assert property (p_dest_work) else $error("work not written");

	property p_dest_file;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(exec && !is_lit && i_instr.dest == 1'b1) |=> o_work == $past(work_reg);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("work changed on file dest");

	property p_shl;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_shl_issue |=> o_flags.carry == $past(f_val[7])
			&& o_result == {$past(f_val[6:0]), 1'b0};
	endproperty
	a_shl: assert property (p_shl) else $error("left shift wrong");

	property p_shr;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_shr_issue |=> o_flags.carry == $past(f_val[0])
			&& o_result == {1'b0, $past(f_val[7:1])};
	endproperty
	a_shr: assert property (p_shr) else $error("right shift wrong");

	property p_shift_zero;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && sh_op) |=> o_flags.zero == (o_result == 8'h00);
	endproperty
	a_shift_zero: assert property (p_shift_zero) else $error("shift zero flag wrong");

	property p_move;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && op == baltu_pkg::move_file) |=> o_done && o_result == $past(f_val);
	endproperty
	a_move: assert property (p_move) else $error("move wrong");

	property p_idle_hold;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_instr.valid |=> $stable(o_flags) && $stable(o_work) && !o_done;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("state changed while idle");

	// checks on file storage and the remaining flag rules
	sequence s_inc_issue;
		i_instr.valid && op == baltu_pkg::increment_file;
	endsequence
	sequence s_move_issue;
		i_instr.valid && op == baltu_pkg::move_file;
	endsequence
	sequence s_lit_issue;
		i_instr.valid && is_lit;
	endsequence
	sequence s_shift_issue;
		i_instr.valid && sh_op;
	endsequence
	sequence s_refused_issue;
		i_instr.valid && !op_known;
	endsequence
	sequence s_file_dest_issue;
		exec && !is_lit && i_instr.dest == `BALTU_DEST_F;
	endsequence

	property p_zero_any;
		@(posedge i_core_clk) disable iff (!i_rstn)
		exec |=> o_flags.zero == (o_result == 8'h00);
	endproperty
	a_zero_any: assert property (p_zero_any) else $error("zero flag wrong");

	// refused words must leave work, flags and result alone and keep done low
	property p_refused;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_refused_issue |=> !o_done && $stable(o_work) && $stable(o_flags)
			&& $stable(o_result);
	endproperty
	a_refused: assert property (p_refused) else $error("refused op changed state");

	property p_or_file_zero;
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_instr.valid && op == baltu_pkg::or_work_with_file)
			|=> o_done && o_flags.zero == (o_result == 8'h00);
	endproperty
	a_or_file_zero: assert property (p_or_file_zero) else $error("or file zero wrong");

	property p_lit_result;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_lit_issue |=> o_done && o_result == o_work;
	endproperty
	a_lit_result: assert property (p_lit_result) else $error("or literal result wrong");

	// literal op never touches file storage, whatever its destination bit
	property p_lit_no_file;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_lit_issue |=> file_mem[$past(f_addr)] == $past(f_val);
	endproperty
	a_lit_no_file: assert property (p_lit_no_file) else $error("or literal wrote file");

	property p_inc_zero;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_inc_issue |=> o_done && o_flags.zero == (o_result == 8'h00);
	endproperty
	a_inc_zero: assert property (p_inc_zero) else $error("increment zero flag wrong");

	property p_inc_wrap;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_inc_issue ##0 (f_val == 8'hff)
			|=> o_result == 8'h00 && o_flags.zero && o_flags.carry == $past(carry_reg);
	endproperty
	a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

	property p_file_write;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_file_dest_issue |=> file_mem[$past(f_addr)] == o_result;
	endproperty
	a_file_write: assert property (p_file_write) else $error("file not written");

	// top location of the seven-bit space must be reachable
	property p_top_addr;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_file_dest_issue ##0 (f_addr == 7'h7f)
			|=> file_mem[`BALTU_FILE_DEPTH-1] == o_result;
	endproperty
	a_top_addr: assert property (p_top_addr) else $error("top file location missed");

	property p_shl_fill;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_shl_issue |=> o_result[0] == 1'b0;
	endproperty
	a_shl_fill: assert property (p_shl_fill) else $error("left shift fill wrong");

	property p_shr_fill;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_shr_issue |=> o_result[7] == 1'b0;
	endproperty
	a_shr_fill: assert property (p_shr_fill) else $error("right shift fill wrong");

	property p_shift_dest;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_shift_issue ##0 (i_instr.dest == `BALTU_DEST_F)
			|=> file_mem[$past(f_addr)] == o_result && $stable(o_work);
	endproperty
	a_shift_dest: assert property (p_shift_dest) else $error("shift destination wrong");

	property p_done;
		@(posedge i_core_clk) disable iff (!i_rstn)
		exec |=> o_done;
	endproperty
	a_done: assert property (p_done) else $error("done pulse missing");

	property p_result_hold;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!exec |=> $stable(o_result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed while idle");

	// rewrite of a file register with its own value, still testing zero
	property p_move_self;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_move_issue ##0 (i_instr.dest == `BALTU_DEST_F)
			|=> file_mem[$past(f_addr)] == $past(f_val) && $stable(o_work)
			&& o_flags.zero == ($past(f_val) == 8'h00);
	endproperty
	a_move_self: assert property (p_move_self) else $error("move to file wrong");
endmodule : baltu_core
`default_nettype wire

// [common/baltu_defs.svh]
// constants for the byte alu datapath
`ifndef BALTU_DEFS_SVH
`define BALTU_DEFS_SVH
`define BALTU_DATA_W 8
`define BALTU_ADDR_W 7
`define BALTU_FILE_DEPTH 128
`define BALTU_OP_W 3
`define BALTU_W_RESET 8'h00
`define BALTU_FILE_RESET 8'h00
`define BALTU_FLAG_RESET 1'b0
`define BALTU_RESULT_RESET 8'h00
`define BALTU_DEST_W 1'b0
`define BALTU_DEST_F 1'b1
`define BALTU_INC_STEP 8'h01
`define BALTU_OP_LATENCY 1
`endif

// [common/baltu_pkg.sv]
// types for the byte alu datapath
package baltu_pkg;
	typedef enum logic [2:0] {
		or_literal_into_work = 3'b000,
		or_work_with_file = 3'b001,
		increment_file = 3'b010,
		shift_left_logical = 3'b011,
		shift_right_logical = 3'b100,
		move_file = 3'b101
	} baltu_op_type;

	typedef struct packed {
		logic valid;
		baltu_op_type op;
		logic [6:0] addr;
		logic dest;
		logic [7:0] literal;
	} baltu_instr_type;

	typedef struct packed {
		logic carry;
		logic zero;
	} baltu_flags_type;
endpackage : baltu_pkg

// [sim/byte_alu_or_inc_shift_move_tb.sv]
// self-checking bench for the byte alu datapath
`timescale 1ns/10ps
`default_nettype none
module byte_alu_or_inc_shift_move_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	baltu_pkg::baltu_instr_type instr = '0;
	logic [7:0] o_work;
	logic [7:0] o_result;
	baltu_pkg::baltu_flags_type o_flags;
	logic o_done;
	logic [7:0] w = 8'h00;
	logic [7:0] res = 8'h00;
	logic [7:0] r;
	logic [7:0] f [128];
	logic c = 1'b0;
	logic z = 1'b0;
	logic ok;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	always #4 clk = ~clk;
	baltu_core i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_instr(instr), .o_work(o_work),
		.o_flags(o_flags), .o_result(o_result), .o_done(o_done));
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// one op, then compare against the bench's own model
	task automatic exec(input logic [2:0] op, input logic [6:0] a, input logic d,
		input logic [7:0] k);
		@(posedge clk);
		#1;
		chk("done low", {7'h00, o_done}, 8'h00);
		instr = {1'b1, op, a, d, k};
		@(posedge clk);
		#1;
		instr.valid = 1'b0;
		ok = 1'b1;
		case (op)
			3'h0: r = w | k;
			3'h1: r = w | f[a];
			3'h2: r = f[a] + 8'h01;
			3'h3: begin
				r = {f[a][6:0], 1'b0};
				c = f[a][7];
			end
			3'h4: begin
				r = {1'b0, f[a][7:1]};
				c = f[a][0];
			end
			3'h5: r = f[a];
			default: ok = 1'b0;
		endcase
		if (ok) begin
			res = r;
			z = (r == 8'h00);
			if (op == 3'h0 || !d)
				w = r;
			else
				f[a] = r;
		end
		chk("work", o_work, w);
		chk("result", o_result, res);
		chk("flags", {6'h00, o_flags}, {6'h00, c, z});
		chk("done", {7'h00, o_done}, {7'h00, ok});
	endtask : exec
	task automatic t_or;
		exec(3'h0, 7'h00, 1'b1, 8'h00);
		exec(3'h0, 7'h7f, 1'b0, 8'ha5);
		exec(3'h1, 7'h7f, 1'b1, 8'hff);
		exec(3'h0, 7'h00, 1'b0, 8'h5a);
		exec(3'h1, 7'h7f, 1'b0, 8'h00);
		$display("test or ended");
	endtask : t_or
	task automatic t_inc;
		exec(3'h1, 7'h01, 1'b1, 8'h00);
		exec(3'h2, 7'h01, 1'b1, 8'h00);
		exec(3'h2, 7'h01, 1'b0, 8'h00);
		$display("test increment ended");
	endtask : t_inc
	task automatic t_shift;
		exec(3'h3, 7'h7f, 1'b0, 8'h00);
		exec(3'h4, 7'h7f, 1'b0, 8'h00);
		exec(3'h3, 7'h01, 1'b1, 8'h00);
		exec(3'h3, 7'h7f, 1'b1, 8'h00);
		exec(3'h2, 7'h7f, 1'b0, 8'h00);
		exec(3'h0, 7'h00, 1'b0, 8'h00);
		$display("test shift ended");
	endtask : t_shift
	task automatic t_move;
		exec(3'h5, 7'h01, 1'b1, 8'h00);
		exec(3'h5, 7'h00, 1'b0, 8'h00);
		exec(3'h5, 7'h7f, 1'b0, 8'h00);
		exec(3'h6, 7'h7f, 1'b1, 8'h00);
		exec(3'h7, 7'h7f, 1'b0, 8'hff);
		$display("test move ended");
	endtask : t_move
	// two ops on consecutive edges, the second reading what the first wrote
	task automatic t_back;
		@(posedge clk);
		#1;
		instr = {1'b1, 3'h1, 7'h02, 1'b1, 8'h00};
		@(posedge clk);
		#1;
		instr = {1'b1, 3'h2, 7'h02, 1'b0, 8'h00};
		f[2] = w | f[2];
		chk("b2b file", o_result, f[2]);
		chk("b2b done", {7'h00, o_done}, 8'h01);
		@(posedge clk);
		#1;
		instr.valid = 1'b0;
		w = f[2] + 8'h01;
		res = w;
		z = (w == 8'h00);
		chk("b2b inc", o_work, w);
		chk("b2b result", o_result, res);
		chk("b2b flags", {6'h00, o_flags}, {6'h00, c, z});
		chk("b2b done", {7'h00, o_done}, 8'h01);
		$display("test back to back ended");
	endtask : t_back
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		foreach (f[i])
			f[i] = 8'h00;
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_or();
		t_inc();
		t_shift();
		t_move();
		t_back();
		summarize();
	end
endmodule : byte_alu_or_inc_shift_move_tb
`default_nettype wire
